// *** rtl/fum_pkg.sv ***
// shared constants and types for the float unit mode and sequencing block
// Notes on behaviour
// - mode bits from opcode plus unload bit0
// - new mode acts one edge after capture
// - controller writes mode before first operand
// - timing bit picks bypass or three stages
// - two round bits pick one of four
// - controller always writes infinity bit zero
// - denorm bit: IEEE or zero substitution
// - flush denormals below two to minus 128
// - pair bypass with IEEE, staged with flush
// - bypass skips pipe registers, one operation
// - upper half then lower half, function first
// - array inputs load one cycle after lower
// - bypass: at least five idles before unloading
// - unload half captured, driven next edge
// - flags loaded on upper unload, held
// - unloading keeps array result intact
// - bypass latency nine cycles overall
// - staged accepts one operation per two cycles
// - mode write enables stages, resets phase
// - mode or idle only after lower half
// - staged pipe advances only on loads
// - staged results every two cycles
// - load command decode of four codes
// - unload command decode, 1x floats outputs
package fum_pkg;

  typedef enum logic [1:0] {
    FUM_IDLE_LOAD  = 2'h0,
    FUM_LOAD_BOTH  = 2'h1,
    FUM_LOAD_FIRST = 2'h2,
    FUM_LOAD_MODE  = 2'h3
  } fum_load_t;

  typedef enum logic [1:0] {
    FUM_UNLOAD_UPPER = 2'h0,
    FUM_UNLOAD_LOWER = 2'h1,
    FUM_OUTPUT_FLOAT = 2'h2
  } fum_unload_t;

  // mode field positions
  localparam int MODE_TIMING_BIT = 0;
  localparam int MODE_ROUND_LO   = 1;
  localparam int MODE_INF_BIT    = 3;
  localparam int MODE_DENORM_BIT = 4;
  localparam logic [4:0] MODE_RESET = 5'h00;

  localparam logic [1:0] ROUND_NEAREST_EVEN = 2'h0;
  localparam logic [1:0] ROUND_TOWARD_ZERO  = 2'h1;
  localparam logic [1:0] ROUND_PLUS_INF     = 2'h2;
  localparam logic [1:0] ROUND_MINUS_INF    = 2'h3;

  // sequencing counts
  localparam logic [3:0] BYPASS_IDLE_CYCLES = 4'h5;
  localparam logic [3:0] STAGED_DRAIN_LOADS = 4'h6;

  // controller register map (byte addresses)
  localparam logic [7:0] ADDR_MODE      = 8'h00;
  localparam logic [7:0] ADDR_OPERAND_A = 8'h04;
  localparam logic [7:0] ADDR_OPERAND_B = 8'h08;
  localparam logic [7:0] ADDR_START     = 8'h0C;
  localparam logic [7:0] ADDR_RESULT    = 8'h10;
  localparam logic [7:0] ADDR_STATUS    = 8'h14;
  localparam int START_LOADB_BIT = 4;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** rtl/fum_link_if.sv ***
// half-word link between the sequencer and the float unit
`timescale 1ns/1ps
interface fum_link_if;
  logic [1:0]  loadCmd;
  logic [1:0]  unloadCmd;
  logic [3:0]  opcode;
  logic [15:0] opAHalf;
  logic [15:0] opBHalf;
  logic [15:0] resultBus;
  logic        resultOe;
  logic [2:0]  flagsBus;

  modport dev (
    input  loadCmd, unloadCmd, opcode, opAHalf, opBHalf,
    output resultBus, resultOe, flagsBus
  );
  modport host (
    output loadCmd, unloadCmd, opcode, opAHalf, opBHalf,
    input  resultBus, resultOe, flagsBus
  );
endinterface

// *** rtl/fum_device.sv ***
// float unit end: input registers, mode, operand phase, stages, unload
`timescale 1ns/1ps
module fum_device
  import fum_pkg::*;
#(
  parameter bit MULT_UNIT = 1'b1
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // link
  fum_link_if.dev          link,
  // arithmetic core
  output logic [31:0]      arrayOpA,
  output logic [31:0]      arrayOpB,
  output logic [3:0]       arrayFunc,
  output logic [1:0]       roundSel,
  output logic             infMode,
  output logic             stagedMode,
  output logic             flushMode,
  input  wire logic [31:0] coreResult,
  input  wire logic [2:0]  coreFlags
);

  // input registers
  logic [1:0]  load_reg;
  logic [1:0]  unload_reg;
  logic [3:0]  opcode_reg;
  logic [15:0] aIn_reg;
  logic [15:0] bIn_reg;
  // mode and phase
  logic [4:0]  mode_reg;
  logic        phaseLower_reg;
  // upper halves held until lower arrives
  logic [15:0] aUpper_reg;
  logic [15:0] bUpper_reg;
  logic [3:0]  funcHold_reg;
  logic        bothHold_reg;
  // array inputs
  logic [31:0] arrA_reg;
  logic [31:0] arrB_reg;
  logic [3:0]  arrFunc_reg;
  // stage registers
  logic [31:0] pipeRes_reg [3];
  logic [2:0]  pipeFlg_reg [3];
  // output registers
  logic [15:0] cOut_reg;
  logic [2:0]  sOut_reg;
  logic        oe_reg;

  function automatic logic [31:0] flushSmall(input logic [31:0] v);
    // magnitude below 2^-128: zero exponent, top two fraction bits zero
    if (v[30:21] == 10'h000) begin
      flushSmall = {v[31], 31'h0};
    end else begin
      flushSmall = v;
    end
  endfunction

  wire        cmdMode   = (load_reg == FUM_LOAD_MODE);
  wire        cmdIdle   = (load_reg == FUM_IDLE_LOAD);
  wire        cmdBoth   = (load_reg == FUM_LOAD_BOTH);
  wire        cmdFirst  = (load_reg == FUM_LOAD_FIRST);
  wire        cmdOperand = cmdBoth | cmdFirst;
  wire        takeUpper = cmdOperand & ~phaseLower_reg;
  wire        takeLower = cmdOperand & phaseLower_reg;
  wire [4:0]  modeCapt  = {opcode_reg, unload_reg[0]};
  wire        staged    = mode_reg[MODE_TIMING_BIT];
  // denormal substitution only on the multiplier
  wire        flushOn   = mode_reg[MODE_DENORM_BIT] & MULT_UNIT;
  // bypass reads core directly, staged reads third stage
  wire [31:0] resRaw    = staged ? pipeRes_reg[2] : coreResult;
  wire [2:0]  flgSel    = staged ? pipeFlg_reg[2] : coreFlags;
  wire [31:0] resSel    = flushOn ? flushSmall(resRaw) : resRaw;
  // unload code rides the mode bit during a mode load, so it is ignored
  wire        unlActive = ~cmdMode;
  wire        unlUpper  = unlActive & (unload_reg == FUM_UNLOAD_UPPER);
  wire        unlLower  = unlActive & (unload_reg == FUM_UNLOAD_LOWER);
  wire        unlFloat  = unlActive & unload_reg[1];

  // one capture edge per latency step
  // capture every command on the edge after it is presented
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      load_reg   <= FUM_IDLE_LOAD;
      unload_reg <= FUM_OUTPUT_FLOAT;
      opcode_reg <= 4'h0;
      aIn_reg    <= 16'h0000;
      bIn_reg    <= 16'h0000;
    end else begin
      load_reg   <= link.loadCmd;
      unload_reg <= link.unloadCmd;
      opcode_reg <= link.opcode;
      aIn_reg    <= link.opAHalf;
      bIn_reg    <= link.opBHalf;
    end
  end

  // mode written one edge after capture
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mode_reg <= MODE_RESET;
    end else if (cmdMode) begin
      mode_reg <= modeCapt;
    end
  end

  // phase reset by mode or idle, alternates on loads
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      phaseLower_reg <= 1'b0;
    end else if (cmdMode || cmdIdle) begin
      phaseLower_reg <= 1'b0;
    end else begin
      phaseLower_reg <= ~phaseLower_reg;
    end
  end

  // function taken with the upper half
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      aUpper_reg   <= 16'h0000;
      bUpper_reg   <= 16'h0000;
      funcHold_reg <= 4'h0;
      bothHold_reg <= 1'b0;
    end else if (takeUpper) begin
      aUpper_reg   <= aIn_reg;
      funcHold_reg <= opcode_reg;
      bothHold_reg <= cmdBoth;
      if (cmdBoth) begin
        bUpper_reg <= bIn_reg;
      end
    end
  end

  // array inputs filled the edge after the lower half
  // held until the next lower half, so unloads keep the result
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      arrA_reg    <= 32'h00000000;
      arrB_reg    <= 32'h00000000;
      arrFunc_reg <= 4'h0;
    end else if (takeLower) begin
      arrA_reg    <= {aUpper_reg, aIn_reg};
      arrFunc_reg <= funcHold_reg;
      // first-only keeps the earlier second operand
      if (bothHold_reg) begin
        arrB_reg <= {bUpper_reg, bIn_reg};
      end
    end
  end

  // stages advance only when a new operand completes
  // one advance per two-cycle operand load
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 3; i++) begin
        pipeRes_reg[i] <= 32'h00000000;
        pipeFlg_reg[i] <= 3'h0;
      end
    end else if (takeLower && staged) begin
      pipeRes_reg[0] <= coreResult;
      pipeFlg_reg[0] <= coreFlags;
      for (int i = 1; i < 3; i++) begin
        pipeRes_reg[i] <= pipeRes_reg[i-1];
        pipeFlg_reg[i] <= pipeFlg_reg[i-1];
      end
    end
  end

  // unload half selected, driven at next edge
  // high code floats the result outputs
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cOut_reg <= 16'h0000;
      oe_reg   <= 1'b0;
    end else if (unlUpper) begin
      cOut_reg <= resSel[31:16];
      oe_reg   <= 1'b1;
    end else if (unlLower) begin
      cOut_reg <= resSel[15:0];
      oe_reg   <= 1'b1;
    end else if (unlFloat) begin
      oe_reg   <= 1'b0;
    end
  end

  // flags with the upper half, kept over the lower unload
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sOut_reg <= 3'h0;
    end else if (unlUpper) begin
      sOut_reg <= flgSel;
    end
  end

  assign arrayOpA   = flushOn ? flushSmall(arrA_reg) : arrA_reg;
  assign arrayOpB   = flushOn ? flushSmall(arrB_reg) : arrB_reg;
  assign arrayFunc  = arrFunc_reg;
  // rounding field out to the core
  assign roundSel   = mode_reg[MODE_ROUND_LO +: 2];
  assign infMode    = mode_reg[MODE_INF_BIT];
  assign stagedMode = staged;
  assign flushMode  = flushOn;

  assign link.resultBus = cOut_reg;
  assign link.resultOe  = oe_reg;
  assign link.flagsBus  = sOut_reg;

endmodule

// *** rtl/fum_host.sv ***
// sequencer end: AXI4-Lite registers driving the half-word link
`timescale 1ns/1ps
module fum_host
  import fum_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // AXI4-Lite write
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // link
  fum_link_if.host         link
);

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0,
    ST_MODE  = 4'h1,
    ST_UPPER = 4'h2,
    ST_LOWER = 4'h3,
    ST_WAIT  = 4'h4,
    ST_UNLHI = 4'h5,
    ST_UNLLO = 4'h6,
    ST_GRBHI = 4'h7,
    ST_GRBLO = 4'h8
  } fum_hstate_t;

  fum_hstate_t state_reg, state_next;
  logic [4:0]  mode_reg;
  logic [31:0] opA_reg;
  logic [31:0] opB_reg;
  logic [3:0]  func_reg;
  logic        both_reg;
  logic [31:0] result_reg;
  logic [2:0]  flags_reg;
  logic [3:0]  cnt_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;

  wire        busy     = (state_reg != ST_IDLE);
  wire        wrTake   = awvalid & wvalid & ~bvalid_reg;
  wire        rdTake   = arvalid & ~rvalid_reg;
  wire        wrMode   = wrTake & (awaddr == ADDR_MODE);
  wire        wrA      = wrTake & (awaddr == ADDR_OPERAND_A);
  wire        wrB      = wrTake & (awaddr == ADDR_OPERAND_B);
  wire        wrStart  = wrTake & (awaddr == ADDR_START);
  wire        wrMapped = wrMode | wrA | wrB | wrStart;
  wire        staged   = mode_reg[MODE_TIMING_BIT];
  wire        cntDone  = (cnt_reg == 4'h1);
  wire [31:0] wrMask   = {{8{wstrb[3]}}, {8{wstrb[2]}},
                          {8{wstrb[1]}}, {8{wstrb[0]}}};
  wire [31:0] rdMux    =
    (araddr == ADDR_MODE)      ? {27'h0, mode_reg} :
    (araddr == ADDR_OPERAND_A) ? opA_reg :
    (araddr == ADDR_OPERAND_B) ? opB_reg :
    (araddr == ADDR_START)     ? {27'h0, both_reg, func_reg} :
    (araddr == ADDR_RESULT)    ? result_reg :
    (araddr == ADDR_STATUS)    ? {28'h0000000, flags_reg, busy} :
                                 32'h00000000;
  wire        rdMapped = (araddr <= ADDR_STATUS) & (araddr[1:0] == 2'h0);

  assign awready = wrTake;
  assign wready  = wrTake;
  assign bvalid  = bvalid_reg;
  assign bresp   = bresp_reg;
  assign arready = rdTake;
  assign rvalid  = rvalid_reg;
  assign rdata   = rdata_reg;
  assign rresp   = rresp_reg;

  // registers; writes during a sequence only update operands
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mode_reg <= MODE_RESET;
      opA_reg  <= 32'h00000000;
      opB_reg  <= 32'h00000000;
      func_reg <= 4'h0;
      both_reg <= 1'b1;
    end else begin
      if (wrMode && !busy) begin
        mode_reg <= wdata[4:0] & ~(5'h01 << MODE_INF_BIT);
      end
      if (wrA) begin
        opA_reg <= (opA_reg & ~wrMask) | (wdata & wrMask);
      end
      if (wrB) begin
        opB_reg <= (opB_reg & ~wrMask) | (wdata & wrMask);
      end
      if (wrStart && !busy) begin
        func_reg <= wdata[3:0];
        both_reg <= wdata[START_LOADB_BIT];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h00000000;
      rresp_reg  <= RESP_OKAY;
    end else begin
      if (wrTake) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wrMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid_reg <= 1'b0;
      end
      if (rdTake) begin
        rvalid_reg <= 1'b1;
        rdata_reg  <= rdMux;
        rresp_reg  <= rdMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // mode loaded before any operand via the mode register
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE:  if (wrMode) state_next = ST_MODE;
                else if (wrStart) state_next = ST_UPPER;
      ST_MODE:  state_next = ST_IDLE;
      ST_UPPER: state_next = ST_LOWER;
      ST_LOWER: state_next = ST_WAIT;
      // idle gap, staged drains with extra loads
      ST_WAIT:  if (cntDone) state_next = ST_UNLHI;
      ST_UNLHI: state_next = ST_UNLLO;
      ST_UNLLO: state_next = ST_GRBHI;
      ST_GRBHI: state_next = ST_GRBLO;
      ST_GRBLO: state_next = ST_IDLE;
      default:  state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg  <= ST_IDLE;
      cnt_reg    <= 4'h0;
      result_reg <= 32'h00000000;
      flags_reg  <= 3'h0;
    end else begin
      state_reg <= state_next;
      if (state_reg == ST_LOWER) begin
        cnt_reg <= staged ? STAGED_DRAIN_LOADS : BYPASS_IDLE_CYCLES;
      end else if (state_reg == ST_WAIT) begin
        cnt_reg <= cnt_reg - 4'h1;
      end
      if (state_reg == ST_GRBHI) begin
        result_reg[31:16] <= link.resultBus;
        flags_reg         <= link.flagsBus;
      end
      if (state_reg == ST_GRBLO) begin
        result_reg[15:0] <= link.resultBus;
      end
    end
  end

  wire inOperand = (state_reg == ST_UPPER) | (state_reg == ST_LOWER);
  wire inDrain   = (state_reg == ST_WAIT) & staged;
  // drain starts on an upper phase: even counts upper, odd counts lower
  wire sendLower = (state_reg == ST_LOWER) | (inDrain & cnt_reg[0]);
  wire [1:0] opLoad = both_reg ? FUM_LOAD_BOTH : FUM_LOAD_FIRST;

  // load codes; idle and mode only after a lower half
  assign link.loadCmd =
    (state_reg == ST_MODE)  ? FUM_LOAD_MODE :
    inOperand               ? opLoad :
    inDrain                 ? FUM_LOAD_BOTH :
                              FUM_IDLE_LOAD;
  // mode spread over opcode and unload bit 0
  assign link.unloadCmd =
    (state_reg == ST_MODE)  ? {1'b1, mode_reg[MODE_TIMING_BIT]} :
    (state_reg == ST_UNLHI) ? FUM_UNLOAD_UPPER :
    (state_reg == ST_UNLLO) ? FUM_UNLOAD_LOWER :
                              FUM_OUTPUT_FLOAT;
  assign link.opcode =
    (state_reg == ST_MODE) ? mode_reg[4:1] : func_reg;
  assign link.opAHalf = sendLower ? opA_reg[15:0] : opA_reg[31:16];
  assign link.opBHalf = sendLower ? opB_reg[15:0] : opB_reg[31:16];

endmodule

// *** verification/fum_link_chk.sv ***
// assertions on the half-word link between sequencer and float unit
`timescale 1ns/1ps
module fum_link_chk (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rstn,
  // link
  input wire logic [1:0]  loadCmd,
  input wire logic [1:0]  unloadCmd,
  input wire logic [3:0]  opcode,
  input wire logic [15:0] opAHalf,
  input wire logic [15:0] opBHalf,
  input wire logic [15:0] resultBus,
  input wire logic        resultOe,
  input wire logic [2:0]  flagsBus
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic       staged_reg;
  logic       staged_next;
  logic [3:0] idleCnt_reg;
  logic [3:0] idleCnt_next;
  wire        idleNow = (loadCmd == 2'h0);
  wire        idleSat = (idleCnt_reg == 4'hF);
  wire        loadNow = (loadCmd == 2'h1) || (loadCmd == 2'h2);
  wire        unlHi   = (unloadCmd == 2'h0) && (loadCmd != 2'h3);
  // timing bit copy, taken from the link on mode loads
  assign staged_next  = (loadCmd == 2'h3) ? unloadCmd[0] : staged_reg;
  assign idleCnt_next = !idleNow ? 4'h0 : idleSat ? 4'hF : idleCnt_reg + 4'h1;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      staged_reg  <= 1'h0;
      idleCnt_reg <= 4'h0;
    end else begin
      staged_reg  <= staged_next;
      idleCnt_reg <= idleCnt_next;
    end
  end
  property p_float_off;
    (unloadCmd[1] && loadCmd != 2'h3) |-> ##2 !resultOe;
  endproperty
  a_float_off: assert property (p_float_off)
    else $error("result outputs still driven");
  property p_upper_on;
    unlHi |-> ##2 resultOe;
  endproperty
  a_upper_on: assert property (p_upper_on)
    else $error("upper half not driven");
  property p_lower_on;
    (unloadCmd == 2'h1 && loadCmd != 2'h3) |-> ##2 resultOe;
  endproperty
  a_lower_on: assert property (p_lower_on)
    else $error("lower half not driven");
  property p_flags_hold;
    !$stable(flagsBus) |-> $past(unloadCmd, 2) == 2'h0;
  endproperty
  a_flags_hold: assert property (p_flags_hold)
    else $error("flags changed without upper unload");
  property p_bus_hold;
    !$stable(resultBus) |-> !$past(unloadCmd[1], 2);
  endproperty
  a_bus_hold: assert property (p_bus_hold)
    else $error("result bus changed without unload");
  property p_halves;
    (loadNow && $past(loadCmd) == 2'h0) |=> loadNow;
  endproperty
  a_halves: assert property (p_halves)
    else $error("upper half not followed by lower half");
  property p_func_hold;
    (loadNow && $past(loadCmd) == 2'h0) |=> $stable(opcode);
  endproperty
  a_func_hold: assert property (p_func_hold)
    else $error("function changed between operand halves");
  property p_drain_repeat;
    (staged_reg && loadNow && $past(loadNow) && $past(loadNow, 2)) |->
      (opAHalf == $past(opAHalf, 2)) && (opBHalf == $past(opBHalf, 2));
  endproperty
  a_drain_repeat: assert property (p_drain_repeat)
    else $error("drain load does not repeat the operand halves");
  property p_mode_idle;
    loadCmd == 2'h3 |=> loadCmd == 2'h0;
  endproperty
  a_mode_idle: assert property (p_mode_idle)
    else $error("operand load right after mode load");
  property p_idle_gap;
    (!staged_reg && unlHi) |-> idleCnt_reg >= 4'h5;
  endproperty
  a_idle_gap: assert property (p_idle_gap)
    else $error("too few idle loads before unload");
  property p_latency;
    (!staged_reg && loadNow && $past(loadCmd) == 2'h0) |->
      ##7 unlHi ##1 unloadCmd == 2'h1 ##1 resultOe [*2];
  endproperty
  a_latency: assert property (p_latency)
    else $error("bypass latency wrong");
  cover property (loadCmd == 2'h3 && unloadCmd[0]);
  cover property (loadCmd == 2'h2);
  cover property (staged_reg && unlHi ##2 resultOe);
endmodule

// *** verification/testbench.sv ***
// self-checking bench: host and float unit joined by the link
`timescale 1ns/1ps
`define CHK(g, e) \
  begin \
    comparisons++; \
    if ((g) !== (e)) begin \
      errors++; \
      $display("[ERR] %0t got %h exp %h", $time, g, e); \
    end \
  end
module testbench
  import fum_pkg::*;
;
  logic        sys_clk;
  logic        rstn;
  logic [31:0] wdata, rdata, arrayOpA, arrayOpB, coreResult;
  logic [7:0]  awaddr, araddr;
  logic [3:0]  wstrb, arrayFunc;
  logic [1:0]  bresp, rresp, roundSel, ebv;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic        infMode, stagedMode, flushMode, flushNow;
  logic [2:0]  coreFlags;
  logic [1:0]  expB[$];
  logic [33:0] expR[$];
  logic [33:0] erv;
  logic [31:0] rnd, opA, opB, lastB;
  logic [4:0]  mode;
  int          errors, comparisons;

  fum_link_if link ();
  fum_host u_fum_host (.sys_clk(sys_clk), .rstn(rstn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .link(link));
  fum_device u_fum_device (.sys_clk(sys_clk), .rstn(rstn), .link(link),
    .arrayOpA(arrayOpA), .arrayOpB(arrayOpB), .arrayFunc(arrayFunc),
    .roundSel(roundSel), .infMode(infMode), .stagedMode(stagedMode),
    .flushMode(flushMode), .coreResult(coreResult), .coreFlags(coreFlags));
  fum_link_chk u_fum_link_chk (.sys_clk(sys_clk), .rstn(rstn),
    .loadCmd(link.loadCmd), .unloadCmd(link.unloadCmd),
    .opcode(link.opcode), .opAHalf(link.opAHalf), .opBHalf(link.opBHalf),
    .resultBus(link.resultBus), .resultOe(link.resultOe),
    .flagsBus(link.flagsBus));

  // core stand-in; exponent never zero so results are never flushed
  assign coreResult = {arrayFunc, 4'h8, arrayOpA[23:12] ^ arrayOpB[11:0],
                       arrayOpA[11:0]};
  assign coreFlags  = arrayFunc[2:0];

  function automatic logic [31:0] model(input logic [31:0] a,
                                        input logic [31:0] b,
                                        input logic [3:0]  f);
    return {f, 4'h8, a[23:12] ^ b[11:0], a[11:0]};
  endfunction
  function automatic logic [31:0] flush(input logic [31:0] v);
    return (flushNow && v[30:21] == 10'h000) ? 32'h0 : v;
  endfunction
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  always #50 sys_clk = ~sys_clk;

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    expB.push_back(r);
    @(posedge sys_clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    do @(posedge sys_clk); while (!(awready && wready));
    awvalid <= 1'h0;
    wvalid  <= 1'h0;
    bready  <= 1'h1;
    do @(posedge sys_clk); while (!bvalid);
    bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    expR.push_back(e);
    @(posedge sys_clk);
    araddr  <= a;
    arvalid <= 1'h1;
    do @(posedge sys_clk); while (!arready);
    arvalid <= 1'h0;
    rready  <= 1'h1;
    do @(posedge sys_clk); while (!rvalid);
    rready <= 1'h0;
  endtask
  task automatic run_op(input logic [3:0] f, input logic both);
    wr(ADDR_OPERAND_A, opA, RESP_OKAY);
    wr(ADDR_OPERAND_B, opB, RESP_OKAY);
    wr(ADDR_START, {27'h0, both, f}, RESP_OKAY);
    if (both) lastB = opB;
    repeat (20) @(posedge sys_clk);
    rd(ADDR_RESULT,
       {RESP_OKAY, model(flush(opA), flush(lastB), f)});
    rd(ADDR_STATUS, {RESP_OKAY, 28'h0, f[2:0], 1'h0});
  endtask
  task automatic complete_run();
    if (errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // response watcher pairs each answer with the oldest note
  always @(posedge sys_clk) begin
    if (bvalid === 1'h1 && bready === 1'h1) begin
      ebv = expB.pop_front();
      `CHK(bresp, ebv)
    end
    if (rvalid === 1'h1 && rready === 1'h1) begin
      erv = expR.pop_front();
      `CHK({rresp, rdata}, erv)
    end
  end

  initial begin
    repeat (6000) @(posedge sys_clk);
    errors++;
    complete_run();
  end

  initial begin
    sys_clk = 1'h0;
    rstn = 1'h0;
    {awaddr, araddr, wdata} = 48'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    wstrb = 4'hF;
    rnd = 32'h3E5F;
    {errors, comparisons} = 64'h0;
    lastB = 32'h0;
    flushNow = 1'h0;
    repeat (12) @(posedge sys_clk);
    rstn <= 1'h1;
    rd(ADDR_STATUS, {RESP_OKAY, 32'h0});
    rd(8'h1C, {RESP_SLVERR, 32'h0});
    wr(8'h1C, 32'h0, RESP_SLVERR);
    for (int i = 0; i < 4; i++) begin
      // staged modes paired with flush
      // inf bit written high on purpose: it must come out cleared
      mode = {i[1], 1'h1, i[1:0], i[1]};
      flushNow = i[1];
      wr(ADDR_MODE, {27'h0, mode}, RESP_OKAY);
      repeat (4) @(posedge sys_clk);
      `CHK(stagedMode, mode[0])
      `CHK(roundSel, mode[2:1])
      `CHK(infMode, 1'h0)
      `CHK(flushMode, mode[4])
      for (int j = 0; j < 3; j++) begin
        rnd = xs(rnd);
        opA = (j == 1) ? 32'h0000_1234 : (rnd | 32'h4000_0000);
        rnd = xs(rnd);
        opB = rnd | 32'h4000_0000;
        run_op(rnd[3:0], j != 2);
      end
    end
    // start and mode writes while busy are answered but ignored
    wr(ADDR_START, {27'h0, 1'h1, 4'h5}, RESP_OKAY);
    wr(ADDR_START, {27'h0, 1'h1, 4'h9}, RESP_OKAY);
    wr(ADDR_MODE, 32'h0, RESP_OKAY);
    repeat (20) @(posedge sys_clk);
    `CHK(stagedMode, 1'h1)
    rd(ADDR_RESULT, {RESP_OKAY, model(opA, opB, 4'h5)});
    complete_run();
  end
endmodule
